// >>> rtl/led_pwm_clock_generation.sv
/*
  LED PWM clock generation: oscillator ticks, control state machine,
  PWM clock source selection, vsync lock and four phase-shifted outputs,
  with a classic Wishbone slave for configuration and status.
  Assumes a 50 MHz clock; vsync, PWM input and enable arrive from pins.
*/
// Chosen here: the Wishbone register port and the address map.
// Operation
// - a 10 MHz tick times the duty measurement of the PWM input
// - the 10 MHz tick halved gives 5 MHz for state machine and timing
// - PWM generator runs from 5 MHz directly or from the multiplier
// - in multiply mode the resolution code selects 5, 10, 20 or 40 MHz PWM clock
// - frequency code selects the counter step, hence the PWM frequency outside sync mode
// - with PLL and sync enabled the PWM clock is locked to vsync
// - restart bit set in sync mode: vsync rising edge restarts the PWM counter
// - external loop filter selected only with slow divider in sync mode
// - three-bit string field sets phase shift between outputs
// - in sync mode the PWM clock derives from vsync; the 10 MHz and 5 MHz ticks stay on the system clock
// - source follows PLL, divider select and sync enable settings
`timescale 1ns/1ns
`include "led_pwm_cfg.svh"

module led_pwm_clock_generation (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        ce,
  // wishbone slave
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [7:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatI,
  output logic [31:0]      wbDatO,
  output logic             wbAck,
  // pins
  input  wire logic        vsync,
  input  wire logic        pwmIn,
  input  wire logic        io_supply_enable_pin,
  output logic [3:0]       ledPwm,
  output logic             extFilterSel
);

  // pin synchronisers: bit 0 vsync, 1 pwm input, 2 enable
  logic [2:0] pinS1_r;
  logic [2:0] pinS2_r;
  logic [2:0] pinS3_r;
  logic [2:0] pinVal_r;
  logic [2:0] pinAgree;
  logic [2:0] pinValNxt;
  logic       vsyncRise;
  logic       pwmInRise;

  assign pinAgree  = ~(pinS2_r ^ pinS3_r);
  assign pinValNxt = (pinAgree & pinS3_r) | (~pinAgree & pinVal_r);
  assign vsyncRise = pinValNxt[0] && !pinVal_r[0];
  assign pwmInRise = pinValNxt[1] && !pinVal_r[1];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pinS1_r  <= 3'h0;
      pinS2_r  <= 3'h0;
      pinS3_r  <= 3'h0;
      pinVal_r <= 3'h0;
    end else if (ce) begin
      pinS1_r  <= {io_supply_enable_pin, pwmIn, vsync};
      pinS2_r  <= pinS1_r;
      pinS3_r  <= pinS2_r;
      pinVal_r <= pinValNxt;
    end
  end

  // oscillator ticks
  logic [2:0] oscCnt_r;
  logic       oscTick;
  logic       halfTog_r;
  logic       baseTick;

  assign oscTick  = (oscCnt_r == 3'(`OSC_TICK_CYC - 1));
  assign baseTick = oscTick && halfTog_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      oscCnt_r  <= 3'h0;
      halfTog_r <= 1'b0;
    end else if (ce) begin
      oscCnt_r  <= oscTick ? 3'h0 : oscCnt_r + 3'h1;
      halfTog_r <= halfTog_r ^ oscTick;
    end
  end

  // input duty measurement in 10 MHz ticks
  logic [15:0] highCnt_r;
  logic [15:0] perCnt_r;
  logic [31:0] inDuty_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      highCnt_r <= 16'h0;
      perCnt_r  <= 16'h0;
      inDuty_r  <= 32'h0;
    end else if (ce) begin
      if (pwmInRise) begin
        inDuty_r  <= {perCnt_r, highCnt_r};
        highCnt_r <= 16'h0;
        perCnt_r  <= 16'h0;
      end else if (oscTick) begin
        if (perCnt_r != 16'hFFFF) perCnt_r <= perCnt_r + 16'h1;
        if (pinVal_r[1] && highCnt_r != 16'hFFFF) begin
          highCnt_r <= highCnt_r + 16'h1;
        end
      end
    end
  end

  // wishbone register file
  logic [31:0] ctrl_r;
  logic [31:0] slowDiv_r;
  logic [15:0] bright_r;
  logic [31:0] active_r;
  logic [31:0] activeDiv_r;
  logic        loaded_r;
  logic        wbAck_r;
  logic [31:0] wbDatO_r;
  logic        wbReq;
  logic        wbWrite;
  logic [31:0] selMask;
  logic        loadReq;
  logic [31:0] rdData;
  logic [31:0] statusWord;
  logic [23:0] vPeriod_r;

  assign wbReq   = wbCyc && wbStb && !wbAck_r;
  assign wbWrite = wbReq && wbWe;
  assign selMask = {{8{wbSel[3]}}, {8{wbSel[2]}}, {8{wbSel[1]}},
                    {8{wbSel[0]}}};
  assign loadReq = wbWrite && (wbAdr == `ADR_CTRL) && wbSel[2]
                   && wbDatI[`CTRL_LOAD];
  assign rdData  =
    (wbAdr == `ADR_CTRL)    ? ctrl_r :
    (wbAdr == `ADR_SLOWDIV) ? slowDiv_r :
    (wbAdr == `ADR_BRIGHT)  ? {16'h0, bright_r} :
    (wbAdr == `ADR_STATUS)  ? statusWord :
    (wbAdr == `ADR_VPERIOD) ? {8'h0, vPeriod_r} :
    (wbAdr == `ADR_INDUTY)  ? inDuty_r : 32'h0;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_r    <= `CTRL_RESET;
      slowDiv_r <= `SLOWDIV_RESET;
      bright_r  <= `BRIGHT_RESET;
      wbAck_r   <= 1'b0;
      wbDatO_r  <= 32'h0;
    end else if (ce) begin
      wbAck_r <= wbReq;
      if (wbReq) wbDatO_r <= rdData;
      if (wbWrite && wbAdr == `ADR_CTRL) begin
        ctrl_r <= (ctrl_r & ~(selMask & `CTRL_MASK))
                  | (wbDatI & selMask & `CTRL_MASK);
      end
      if (wbWrite && wbAdr == `ADR_SLOWDIV) begin
        slowDiv_r <= (slowDiv_r & ~(selMask & `SLOWDIV_MASK))
                     | (wbDatI & selMask & `SLOWDIV_MASK);
      end
      if (wbWrite && wbAdr == `ADR_BRIGHT) begin
        bright_r <= (bright_r & ~selMask[15:0])
                    | (wbDatI[15:0] & selMask[15:0]);
      end
    end
  end

  // shadow copy taken on load; brightness is not shadowed and changes at once
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      active_r    <= `CTRL_RESET;
      activeDiv_r <= `SLOWDIV_RESET;
      loaded_r    <= 1'b0;
    end else if (ce && loadReq) begin
      active_r    <= (wbDatI & `CTRL_MASK);
      activeDiv_r <= slowDiv_r;
      loaded_r    <= 1'b1;
    end
  end

  // active configuration fields
  logic [3:0]  freqCode;
  logic [1:0]  resCode;
  logic        enPll;
  logic        enSync;
  logic        selDivider;
  logic        counterRestart;
  logic [2:0]  string_phase_config;
  logic        slowEn;
  logic [12:0] slowDiv;
  logic [3:0]  preDiv;
  logic [159:0] stepLut;
  logic [9:0]  baseStep;
  logic [9:0]  stepEff;
  logic [7:0]  lutIdx;

  assign freqCode            = active_r[`CTRL_FREQ_LSB +: 4];
  assign resCode             = active_r[`CTRL_RES_LSB +: 2];
  assign enPll               = active_r[`CTRL_EN_PLL];
  assign enSync              = active_r[`CTRL_EN_SYNC];
  assign selDivider          = active_r[`CTRL_SEL_DIV];
  assign counterRestart      = active_r[`CTRL_RESTART];
  assign string_phase_config = active_r[`CTRL_PHASE_LSB +: 3];
  assign slowEn              = active_r[`CTRL_SLOW_EN];
  assign slowDiv = slowEn ? activeDiv_r[`SLOW_DIV_LSB +: 13] : 13'h1;
  assign preDiv  = (activeDiv_r[`SLOW_PRE_LSB +: 4] == 4'h0) ? 4'h1
                   : activeDiv_r[`SLOW_PRE_LSB +: 4];
  assign stepLut  = `STEP_LUT;
  // eight index bits: code 15 lands at bit 150
  assign lutIdx   = {1'b0, freqCode, 3'h0} + {3'h0, freqCode, 1'h0};
  assign baseStep = stepLut[lutIdx +: 10];
  // smaller step: same frequency with the multiplier or vsync clock, lower from the 5 MHz base
  assign stepEff  = baseStep >> resCode;

  // vsync period measurement and lock
  logic [23:0] vCnt_r;
  logic [1:0]  vEdges_r;
  logic        locked;

  assign locked = (vEdges_r == 2'h2);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      vCnt_r    <= 24'h0;
      vPeriod_r <= 24'h0;
      vEdges_r  <= 2'h0;
    end else if (ce) begin
      if (!enSync || vCnt_r == `VSYNC_CNT_MAX) begin
        vEdges_r <= 2'h0;
        vCnt_r   <= 24'h0;
      end else if (vsyncRise) begin
        vCnt_r <= 24'h0;
        if (vEdges_r != 2'h0) vPeriod_r <= vCnt_r + 24'h1;
        if (!locked) vEdges_r <= vEdges_r + 2'h1;
      end else begin
        vCnt_r <= vCnt_r + 24'h1;
      end
    end
  end

  // control state machine, stepped by the 5 MHz tick
  led_pwm_pkg::ctrl_state_type state_r;
  led_pwm_pkg::ctrl_state_type state_nxt;
  led_pwm_pkg::clk_source_type source;

  always_comb begin
    state_nxt = state_r;
    if (!pinVal_r[2]) begin
      state_nxt = led_pwm_pkg::ST_OFF;
    end else if (!loaded_r) begin
      state_nxt = led_pwm_pkg::ST_BYPASS;
    end else if (enPll && enSync) begin
      state_nxt = locked ? led_pwm_pkg::ST_SYNCED
                         : led_pwm_pkg::ST_SYNC_WAIT;
    end else if (enPll && selDivider) begin
      state_nxt = led_pwm_pkg::ST_MULTIPLY;
    end else begin
      state_nxt = led_pwm_pkg::ST_INTERNAL;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_r <= led_pwm_pkg::ST_OFF;
    end else if (ce && baseTick) begin
      state_r <= state_nxt;
    end
  end

  always_comb begin
    case (state_r)
      led_pwm_pkg::ST_BYPASS:   source = led_pwm_pkg::SRC_BASE;
      led_pwm_pkg::ST_INTERNAL: source = led_pwm_pkg::SRC_BASE;
      led_pwm_pkg::ST_MULTIPLY: source = led_pwm_pkg::SRC_MULT;
      led_pwm_pkg::ST_SYNCED:   source = led_pwm_pkg::SRC_VSYNC;
      default:                  source = led_pwm_pkg::SRC_NONE;
    endcase
  end

  // fractional clock synthesis: inc/thr of the system clock
  logic [39:0] acc_r;
  logic [39:0] inc;
  logic [39:0] thr;
  logic [39:0] accSum;
  logic        pwmTick;
  logic [15:0] phase_r;
  logic        restart;
  logic [5:0]  multMhz;
  logic        run;

  assign multMhz = 6'(`BASE_PWM_MHZ) << resCode;
  assign inc =
    (source == led_pwm_pkg::SRC_VSYNC) ? {11'h0, slowDiv, 16'h0} :
    (source == led_pwm_pkg::SRC_MULT)  ? {34'h0, multMhz} :
    40'(`BASE_PWM_MHZ);
  // vsync source: counter wraps slowDiv/preDiv times per vsync period
  assign thr = (source == led_pwm_pkg::SRC_VSYNC)
               ? {30'h0, stepEff} * {16'h0, vPeriod_r} * {36'h0, preDiv}
               : 40'(`SYS_CLK_MHZ);
  assign accSum  = acc_r + inc;
  assign pwmTick = (source != led_pwm_pkg::SRC_NONE) && (accSum >= thr);
  assign restart = counterRestart && vsyncRise
                   && (source == led_pwm_pkg::SRC_VSYNC);
  assign run     = (source != led_pwm_pkg::SRC_NONE);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      acc_r   <= 40'h0;
      phase_r <= 16'h0;
    end else if (ce) begin
      if (restart || !run) begin
        acc_r   <= 40'h0;
        phase_r <= 16'h0;
      end else begin
        acc_r <= pwmTick ? accSum - thr : accSum;
        if (pwmTick) phase_r <= phase_r + {6'h0, stepEff};
      end
    end
  end

  // loop filter selection
  logic extFilterSel_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      extFilterSel_r <= 1'b0;
    end else if (ce) begin
      extFilterSel_r <= loaded_r && enPll && enSync && slowEn;
    end
  end

  // phase-shifted outputs
  logic [15:0] phaseOffset;

  assign phaseOffset = {string_phase_config, 13'h0};

  for (genvar ch = 0; ch < 4; ch++) begin : gen_ch
    pwm_phase_counter #(
      .CHANNEL (2'(ch))
    ) u_ch (
      .clock  (clock),
      .nrst   (nrst),
      .ce     (ce),
      .phase  (phase_r),
      .offset (phaseOffset),
      .duty   (bright_r),
      .run    (run),
      .pwmOut (ledPwm[ch])
    );
  end

  assign statusWord   = {25'h0, source, pinVal_r[2], locked, state_r};
  assign wbAck        = wbAck_r;
  assign wbDatO       = wbDatO_r;
  assign extFilterSel = extFilterSel_r;

endmodule : led_pwm_clock_generation

// >>> rtl/led_pwm_cfg.svh
/*
  Offsets, field positions, reset values and timing counts of the
  LED PWM clock generation block, as text macros.
  Assumes inclusion by bare name from the design files.
*/
`ifndef LED_PWM_CFG_SVH
`define LED_PWM_CFG_SVH

// clocking
`define SYS_CLK_MHZ     50
`define OSC_MHZ         10
`define OSC_TICK_CYC    (`SYS_CLK_MHZ / `OSC_MHZ)
`define BASE_PWM_MHZ    5

// register byte addresses
`define ADR_CTRL        8'h00
`define ADR_SLOWDIV     8'h04
`define ADR_BRIGHT      8'h08
`define ADR_STATUS      8'h0C
`define ADR_VPERIOD     8'h10
`define ADR_INDUTY      8'h14

// control register fields
`define CTRL_FREQ_LSB   0
`define CTRL_RES_LSB    4
`define CTRL_EN_PLL     6
`define CTRL_EN_SYNC    7
`define CTRL_SEL_DIV    8
`define CTRL_RESTART    9
`define CTRL_PHASE_LSB  10
`define CTRL_SLOW_EN    13
`define CTRL_LOAD       16
`define CTRL_MASK       32'h0000_3FFF
`define CTRL_RESET      32'h0000_0000

// slow divider register fields, brightness reset value
`define SLOW_DIV_LSB    0
`define SLOW_PRE_LSB    16
`define SLOWDIV_MASK    32'h000F_1FFF
`define SLOWDIV_RESET   32'h0001_0001
`define BRIGHT_RESET    16'h8000

// counter step per 5 MHz clock, index = frequency code, ten bits each
`define STEP_LUT {10'h200, 10'h1C0, 10'h190, 10'h180, 10'h170, 10'h160, \
                  10'h150, 10'h140, 10'h130, 10'h120, 10'h110, 10'h100, \
                  10'h0E0, 10'h0B0, 10'h080, 10'h040}

// vsync period counter restarts from zero here: treated as lost
`define VSYNC_CNT_MAX   24'hFFFFFF

`endif

// >>> rtl/led_pwm_pkg.sv
/*
  Types shared by the LED PWM clock generation design.
  Assumes nothing of its surroundings.
*/
package led_pwm_pkg;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_BYPASS,
    ST_INTERNAL,
    ST_MULTIPLY,
    ST_SYNC_WAIT,
    ST_SYNCED
  } ctrl_state_type;

  typedef enum logic [1:0] {
    SRC_BASE,
    SRC_MULT,
    SRC_VSYNC,
    SRC_NONE
  } clk_source_type;

endpackage : led_pwm_pkg

// >>> rtl/pwm_phase_counter.sv
/*
  One LED PWM output: shifts the shared counter phase by its channel
  offset and compares against the duty value.
  Assumes phase, offset and duty are synchronous to clock.
*/
`timescale 1ns/1ns

module pwm_phase_counter #(
  parameter logic [1:0] CHANNEL = 2'h0
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        ce,
  // shared counter
  input  wire logic [15:0] phase,
  input  wire logic [15:0] offset,
  input  wire logic [15:0] duty,
  input  wire logic        run,
  // output
  output logic             pwmOut
);

  logic [17:0] shiftProd;
  logic [15:0] chPhase;
  logic        pwmOn;
  logic        pwmOut_r;

  assign shiftProd = offset * CHANNEL;
  assign chPhase   = phase - shiftProd[15:0];
  assign pwmOn     = run && (chPhase < duty);
  assign pwmOut    = pwmOut_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pwmOut_r <= 1'b0;
    end else if (ce) begin
      pwmOut_r <= pwmOn;
    end
  end

endmodule : pwm_phase_counter

// >>> tb/led_pwm_sva.sv
/* Port checks for the LED PWM clock generation block.
   Assumes it is bound onto led_pwm_clock_generation. */
`timescale 1ns/1ns
`include "led_pwm_cfg.svh"
module led_pwm_sva (
  // clock and reset
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        ce,
  // wishbone
  input wire logic        wbCyc,
  input wire logic        wbStb,
  input wire logic        wbWe,
  input wire logic [7:0]  wbAdr,
  input wire logic [3:0]  wbSel,
  input wire logic [31:0] wbDatI,
  input wire logic [31:0] wbDatO,
  input wire logic        wbAck,
  // pins
  input wire logic        io_supply_enable_pin,
  input wire logic [3:0]  ledPwm,
  input wire logic        extFilterSel
);
  logic       filt_r;
  logic [4:0] offCnt_r;
  wire logic  loadHit = wbCyc && wbStb && wbAck && wbWe && ce &&
    wbAdr == `ADR_CTRL && wbSel[2] && wbDatI[`CTRL_LOAD];
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      filt_r <= 1'b0;
    else if (loadHit)
      filt_r <= wbDatI[`CTRL_SLOW_EN] & wbDatI[`CTRL_EN_SYNC]
                & wbDatI[`CTRL_EN_PLL];
  // long enough to cover pin sync plus one 5 MHz tick
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      offCnt_r <= 5'h00;
    else if (io_supply_enable_pin)
      offCnt_r <= 5'h00;
    else if (offCnt_r != 5'h18)
      offCnt_r <= offCnt_r + 5'h01;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence wbReq;
    wbCyc && wbStb && !wbAck && ce;
  endsequence
  sequence wbRd;
    wbCyc && wbStb && !wbWe && wbAck;
  endsequence
  ack_next_a:
    assert property (wbReq |=> wbAck) else $error("ack missing");
  ack_pulse_a:
    assert property (wbAck && ce |=> !wbAck) else $error("ack too long");
  ack_idle_a:
    assert property (!(wbCyc && wbStb) && ce |=> !wbAck)
    else $error("ack without request");
  unmapped_zero_a:
    assert property (wbRd ##0 wbAdr == 8'h20 |-> wbDatO == 32'h0)
    else $error("unmapped read not zero");
  ctrl_upper_a:
    assert property (wbRd ##0 wbAdr == `ADR_CTRL |-> wbDatO[31:14] == 18'h0)
    else $error("control upper bits not zero");
  reset_quiet_a:
    assert property ($rose(nrst) |-> ledPwm == 4'h0 && !extFilterSel)
    else $error("outputs active at reset release");
  enable_off_a:
    assert property (offCnt_r == 5'h18 |-> ledPwm == 4'h0)
    else $error("outputs active while disabled");
  filt_on_a:
    assert property ($rose(filt_r) |-> ##[1:12] extFilterSel)
    else $error("external filter not selected");
  filt_off_a:
    assert property ($fell(filt_r) |-> ##[1:12] !extFilterSel)
    else $error("external filter left selected");
endmodule : led_pwm_sva

bind led_pwm_clock_generation led_pwm_sva u_sva (
  .clock(clock), .nrst(nrst), .ce(ce), .wbCyc(wbCyc), .wbStb(wbStb),
  .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI),
  .wbDatO(wbDatO), .wbAck(wbAck),
  .io_supply_enable_pin(io_supply_enable_pin), .ledPwm(ledPwm),
  .extFilterSel(extFilterSel));

// >>> tb/vsync_source.sv
/* Video timing source: periodic vsync pulses.
   Assumes a free-running clock; run gates the pulses. */
`timescale 1ns/1ns
module vsync_source #(
  parameter int PERIOD = 2000
) (
  // clock
  input  wire logic clock,
  // control
  input  wire logic run,
  // pin
  output logic      vsync = 1'b0
);
  int cnt = 0;
  // runs from time zero, so it is up before enable rises
  always @(posedge clock) begin
    cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    vsync <= run && cnt < 40;
  end
endmodule : vsync_source

// >>> tb/testbench.sv
/* Self-checking bench for the LED PWM clock generation block.
   Assumes the design, its bound checker and the vsync source. */
`timescale 1ns/1ns
`include "led_pwm_cfg.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  num_errors++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module testbench;
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  logic [3:0]  held;
  logic        wbCyc = 1'b0;
  logic        wbStb = 1'b0;
  logic        wbWe = 1'b0;
  logic [7:0]  wbAdr = 8'h00;
  logic [3:0]  wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h0;
  logic [31:0] wbDatO;
  logic [31:0] rd;
  logic        wbAck;
  logic        vsync;
  logic        pwmIn = 1'b0;
  logic        io_supply_enable_pin = 1'b0;
  logic [3:0]  ledPwm;
  logic        extFilterSel;
  int          num_errors = 0;
  int          compares = 0;
  int          per;
  int          hz [16] = '{0, 0, 13428, 17090, 19531, 20752, 21973, 23192,
    24412, 25635, 26855, 28076, 29297, 30518, 34180, 39063};

  led_pwm_clock_generation u_dut (.clock(clock), .nrst(nrst), .ce(ce),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
    .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck),
    .vsync(vsync), .pwmIn(pwmIn),
    .io_supply_enable_pin(io_supply_enable_pin), .ledPwm(ledPwm),
    .extFilterSel(extFilterSel));
  vsync_source #(.PERIOD(2000)) u_vsync (.clock(clock), .run(1'b1),
    .vsync(vsync));

  initial forever #10 clock = ~clock;
  // 300 of 1000 clocks high: 60 of 200 ticks at 10 MHz
  initial forever begin
    repeat (700) @(posedge clock);
    pwmIn <= 1'b1;
    repeat (300) @(posedge clock);
    pwmIn <= 1'b0;
  end

  task automatic xfer(input logic we, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbSel <= s;
    wbDatI <= d;
    // no cycle limit here: the watchdog ends a hung transfer
    do begin
      @(posedge clock);
    end while (wbAck !== 1'b1);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : xfer

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'hF);
    `CHK("read", e, rd)
  endtask : rdChk

  task automatic load(input logic [31:0] c);
    xfer(1'b1, `ADR_CTRL, c | 32'h0001_0000, 4'hF);
    repeat (40) @(posedge clock);
  endtask : load

  // cycles until the next rising edge of one output
  task automatic rise(input int ch);
    logic p;
    per = 1;
    @(negedge clock);
    p = ledPwm[ch];
    while (!(p === 1'b0 && ledPwm[ch] === 1'b1) && per < 20000) begin
      p = ledPwm[ch];
      @(negedge clock);
      per++;
    end
  endtask : rise

  task automatic near(input string nm, input int e);
    `CHK(nm, 1'b1, per > e - 12 && per < e + 12)
  endtask : near

  task automatic finish_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (105000) @(posedge clock);
    num_errors++;
    finish_test();
  end

  initial begin
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    io_supply_enable_pin <= 1'b1;
    rdChk(`ADR_CTRL, `CTRL_RESET);
    rdChk(`ADR_SLOWDIV, `SLOWDIV_RESET);
    rdChk(`ADR_BRIGHT, {16'h0, `BRIGHT_RESET});
    rdChk(8'h20, 32'h0);
    xfer(1'b1, `ADR_BRIGHT, 32'h0000_1234, 4'h1);
    rdChk(`ADR_BRIGHT, 32'h0000_8034);
    // load bit set but its lane unselected: nothing goes active
    xfer(1'b1, `ADR_CTRL, 32'hFFFF_002F, 4'h3);
    repeat (40) @(posedge clock);
    rdChk(`ADR_CTRL, 32'h0000_002F);
    xfer(1'b1, `ADR_STATUS, 32'h0, 4'hF);
    rdChk(`ADR_STATUS, 32'h0000_0011);
    for (int c = 2; c < 16; c++) begin
      load(c);
      rise(0);
      rise(0);
      near("period", 50000000 / hz[c]);
    end
    rdChk(`ADR_STATUS, 32'h0000_0012);
    rdChk(`ADR_INDUTY, 32'h00C8_003C);
    for (int r = 0; r < 4; r++) begin
      load(32'h0000_014F | (r << 4));
      rdChk(`ADR_STATUS, 32'h0000_0033);
      rise(0);
      rise(0);
      near("mult period", 1280);
    end
    // ce low must freeze outputs across a whole PWM half period
    @(posedge clock);
    ce <= 1'b0;
    @(negedge clock);
    held = ledPwm;
    for (int k = 0; k < 7; k++) begin
      repeat (100) @(negedge clock);
      `CHK("frozen outputs", held, ledPwm)
    end
    @(posedge clock);
    ce <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      load(32'h0000_000F | (s << 10));
      rise(0);
      rise(1);
      near("phase lag", ((s + 7) % 8 + 1) * 160);
    end
    xfer(1'b1, `ADR_SLOWDIV, 32'h0001_0002, 4'hF);
    load(32'h0000_26CF);
    repeat (6000) @(posedge clock);
    rdChk(`ADR_STATUS, 32'h0000_005D);
    rdChk(`ADR_VPERIOD, 32'h0000_07D0);
    `CHK("filter on", 1'b1, extFilterSel)
    rise(0);
    rise(0);
    near("sync period", 1000);
    @(posedge vsync);
    repeat (8) @(negedge clock);
    `CHK("restart", 4'h1, ledPwm & 4'h3)
    @(posedge clock);
    load(32'h0000_000F);
    `CHK("filter off", 1'b0, extFilterSel)
    io_supply_enable_pin <= 1'b0;
    repeat (40) @(posedge clock);
    @(negedge clock);
    `CHK("disabled outputs", 4'h0, ledPwm)
    finish_test();
  end
endmodule : testbench
